/* File: spdic_regs.svh */
// register addresses, field positions and reset values of the serial port
// dma and interrupt request control; included by its bare name, definitions only
`ifndef SPDIC_REGS_SVH
`define SPDIC_REGS_SVH

// ----------------------------------------------------------------------------
// register addresses, one set per channel
// ----------------------------------------------------------------------------
`define SPDIC_ADDR_CTRL_CH0   16'hf304
`define SPDIC_ADDR_STAT_CH0   16'hf308
`define SPDIC_ADDR_SCHG_CH0   16'hf30c
`define SPDIC_ADDR_CTRL_CH1   16'hf404
`define SPDIC_ADDR_STAT_CH1   16'hf408
`define SPDIC_ADDR_SCHG_CH1   16'hf40c

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SPDIC_CTRL_TX_DMA     15
`define SPDIC_CTRL_RX_DMA     14
`define SPDIC_CTRL_TX_IRQ     13
`define SPDIC_CTRL_RX_IRQ     12
`define SPDIC_CTRL_ERR_IRQ    11
`define SPDIC_CTRL_CTS_HI     10
`define SPDIC_CTRL_CTS_LO     9
`define SPDIC_CTRL_SEL_HI     5
`define SPDIC_CTRL_SEL_LO     0
`define SPDIC_CTRL_RESET      16'h0000

// ----------------------------------------------------------------------------
// dma and interrupt status register fields
// ----------------------------------------------------------------------------
`define SPDIC_STAT_HEAD_HI    15
`define SPDIC_STAT_HEAD_LO    11
`define SPDIC_STAT_ERR        10
`define SPDIC_STAT_RX_TIMEOUT_FLAG       9
`define SPDIC_STAT_TXSP       8
`define SPDIC_STAT_RXFULL     7
`define SPDIC_STAT_SCHG       6
`define SPDIC_STAT_CNT_HI     4
`define SPDIC_STAT_CNT_LO     0
`define SPDIC_TXSP_RESET      1'b1

// ----------------------------------------------------------------------------
// status change register fields, also the positions of the select bits
// ----------------------------------------------------------------------------
`define SPDIC_SCHG_OVR        5
`define SPDIC_SCHG_CTS        4
`define SPDIC_SCHG_BRK        3
`define SPDIC_SCHG_TX_READY_STATUS       2
`define SPDIC_SCHG_ALLS       1

`endif

/* File: spdic_pkg.sv */
// types shared by the serial port dma and interrupt request control
// assumes nothing of its surroundings
package spdic_pkg;

    // cts edge condition that counts as a status change
    typedef enum logic [1:0] {
        SPDIC_CTS_NONE = 2'b00,
        SPDIC_CTS_RISE = 2'b01,
        SPDIC_CTS_FALL = 2'b10,
        SPDIC_CTS_BOTH = 2'b11
    } spdic_cts_cond_t;

endpackage : spdic_pkg

/* File: spdic_stchg_if.sv */
// bundle between the control block and its status change detector
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface spdic_stchg_if;
    logic                      overrun_status;   // latched overrun bit
    logic                      cts_level_status; // filtered cts level
    logic                      break_detected;
    logic                      tx_ready_status;
    logic                      tx_all_sent;
    logic [5:0]                status_change_select;
    spdic_pkg::spdic_cts_cond_t cts_edge_condition;
    logic                      hit;              // some selected condition occurred

    modport src (
        output overrun_status, cts_level_status, break_detected, tx_ready_status,
               tx_all_sent, status_change_select, cts_edge_condition,
        input  hit
    );
    modport det (
        input  overrun_status, cts_level_status, break_detected, tx_ready_status,
               tx_all_sent, status_change_select, cts_edge_condition,
        output hit
    );
endinterface : spdic_stchg_if

/* File: spdic_stchg.sv */
// status change detector: edges and levels of the line status bits, gated
// by the status change select field; assumes inputs are on clk_i already
`timescale 1ns/1ps
`include "spdic_regs.svh"

module spdic_stchg (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // status bits in, hit out
    spdic_stchg_if.det sc
);

    logic cts_prev;
    logic brk_prev;
    logic tx_ready_status_prev;
    logic alls_prev;

    // ------------------------------------------------------------------------
    // condition decode
    // ------------------------------------------------------------------------
    wire cts_rise = sc.cts_level_status & ~cts_prev;
    wire cts_fall = ~sc.cts_level_status & cts_prev;
    wire cts_hit  = ((sc.cts_edge_condition == spdic_pkg::SPDIC_CTS_RISE) & cts_rise)
                  | ((sc.cts_edge_condition == spdic_pkg::SPDIC_CTS_FALL) & cts_fall)
                  | ((sc.cts_edge_condition == spdic_pkg::SPDIC_CTS_BOTH) & (cts_rise | cts_fall));

    // each selected condition contributes; all-zero select detects nothing
    assign sc.hit = (sc.status_change_select[`SPDIC_SCHG_OVR] & sc.overrun_status)
                  | (sc.status_change_select[`SPDIC_SCHG_CTS] & cts_hit)
                  | (sc.status_change_select[`SPDIC_SCHG_BRK] & sc.break_detected & ~brk_prev)
                  | (sc.status_change_select[`SPDIC_SCHG_TX_READY_STATUS] & sc.tx_ready_status & ~tx_ready_status_prev)
                  | (sc.status_change_select[`SPDIC_SCHG_ALLS] & sc.tx_all_sent & ~alls_prev);

    // previous values for the becomes-1 and edge conditions
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cts_prev  <= 1'b0;
            brk_prev  <= 1'b0;
            tx_ready_status_prev <= 1'b0;
            alls_prev <= 1'b0;
        end else begin
            cts_prev  <= sc.cts_level_status;
            brk_prev  <= sc.break_detected;
            tx_ready_status_prev <= sc.tx_ready_status;
            alls_prev <= sc.tx_all_sent;
        end
    end

endmodule : spdic_stchg

/* File: spdic_top.sv */
// serial port dma and interrupt request control, one channel
// assumes the line logic drives its status inputs on clk_i; the cts pin is
// asynchronous; the register master follows the plain strobe protocol
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "spdic_regs.svh"

module spdic_top #(
    parameter bit CHANNEL = 1'b0   // selects the channel 1 address set
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // register port
    input  wire logic [15:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // line logic status, same clock
    input  wire logic        tx_space_lvl_i,   // tx fifo free space at trigger level
    input  wire logic        rx_full_lvl_i,    // rx fifo fill at trigger level
    input  wire logic        rx_timeout_i,     // one-cycle pulse
    input  wire logic        rx_error_i,       // one-cycle pulse: frame, parity or overrun
    input  wire logic        overrun_i,        // one-cycle pulse
    input  wire logic        break_detected_i, // level
    input  wire logic        tx_ready_i,       // level
    input  wire logic        tx_all_sent_i,    // level
    input  wire logic [4:0]  rx_count_i,       // entries in rx fifo
    input  wire logic [4:0]  rx_head_i,        // status of rx fifo head entry
    // pin
    input  wire logic        cts_pin_i,
    // dma controller
    input  wire logic        tx_dma_ack_i,
    input  wire logic        rx_dma_ack_i,
    output logic             tx_dma_req_o,
    output logic             rx_dma_req_o,
    // mode and interrupt
    output logic             tx_dma_mode_o,
    output logic             rx_dma_mode_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------------

    // latched flag: hardware set wins over a write-zero clear
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic clr
    );
        flag_next = set | (cur & ~clr);
    endfunction : flag_next

    // a write of zero to a given bit clears it; a one leaves it alone
    function automatic logic wr_zero(
        input logic        sel,
        input logic [31:0] data,
        input int          pos
    );
        wr_zero = sel & ~data[pos];
    endfunction : wr_zero

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------

    // named so its bits can be selected
    localparam logic [15:0] CTRL_RESET_VAL = `SPDIC_CTRL_RESET;

    // control fields
    logic                       tx_dma_enable;
    logic                       rx_dma_enable;
    logic                       tx_space_irq_enable;
    logic                       rx_full_irq_enable;
    logic                       rx_error_irq_enable;
    spdic_pkg::spdic_cts_cond_t cts_edge_condition;
    logic [5:0]                 status_change_select;

    // latched flags
    logic                       rx_error_flag;
    logic                       rx_timeout_flag;
    logic                       tx_space_flag;
    logic                       rx_full_flag;
    logic                       status_change_flag;
    logic                       overrun_status;

    // cts stages
    logic                       cts_s1;
    logic                       cts_s2;
    logic                       cts_s3;
    logic                       cts_level_status;

    // next flag values
    logic                       next_rx_error_flag;
    logic                       next_rx_timeout_flag;
    logic                       next_tx_space_flag;
    logic                       next_rx_full_flag;
    logic                       next_status_change_flag;
    logic                       next_overrun_status;
    logic [31:0]                next_rdata;

    // detector bundle
    spdic_stchg_if              stchg ();

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    // channel picks the address set
    wire [15:0] addr_ctrl = CHANNEL ? `SPDIC_ADDR_CTRL_CH1 : `SPDIC_ADDR_CTRL_CH0;
    wire [15:0] addr_stat = CHANNEL ? `SPDIC_ADDR_STAT_CH1 : `SPDIC_ADDR_STAT_CH0;
    wire [15:0] addr_schg = CHANNEL ? `SPDIC_ADDR_SCHG_CH1 : `SPDIC_ADDR_SCHG_CH0;

    // one compare per register
    wire hit_ctrl = (addr_i == addr_ctrl);
    wire hit_stat = (addr_i == addr_stat);
    wire hit_schg = (addr_i == addr_schg);

    // unmapped writes are dropped
    wire wr_ctrl  = wr_i & hit_ctrl;
    wire wr_stat  = wr_i & hit_stat;
    wire wr_schg  = wr_i & hit_schg;

    // ------------------------------------------------------------------------
    // register images for reads
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_image;
    logic [31:0] stat_image;
    logic [31:0] schg_image;

    // reserved bits read as zero
    always_comb begin
        ctrl_image = 32'h0000_0000;
        ctrl_image[`SPDIC_CTRL_TX_DMA]  = tx_dma_enable;
        ctrl_image[`SPDIC_CTRL_RX_DMA]  = rx_dma_enable;
        ctrl_image[`SPDIC_CTRL_TX_IRQ]  = tx_space_irq_enable;
        ctrl_image[`SPDIC_CTRL_RX_IRQ]  = rx_full_irq_enable;
        ctrl_image[`SPDIC_CTRL_ERR_IRQ] = rx_error_irq_enable;
        ctrl_image[`SPDIC_CTRL_CTS_HI:`SPDIC_CTRL_CTS_LO] = cts_edge_condition;
        ctrl_image[`SPDIC_CTRL_SEL_HI:`SPDIC_CTRL_SEL_LO] = status_change_select;
    end

    // count and head are live, not latched
    always_comb begin
        stat_image = 32'h0000_0000;
        stat_image[`SPDIC_STAT_HEAD_HI:`SPDIC_STAT_HEAD_LO] = rx_head_i;
        stat_image[`SPDIC_STAT_ERR]    = rx_error_flag;
        stat_image[`SPDIC_STAT_RX_TIMEOUT_FLAG]   = rx_timeout_flag;
        stat_image[`SPDIC_STAT_TXSP]   = tx_space_flag;
        stat_image[`SPDIC_STAT_RXFULL] = rx_full_flag;
        stat_image[`SPDIC_STAT_SCHG]   = status_change_flag;
        stat_image[`SPDIC_STAT_CNT_HI:`SPDIC_STAT_CNT_LO] = rx_count_i;
    end

    // the status change register shows live line levels beside the latch
    always_comb begin
        schg_image = 32'h0000_0000;
        schg_image[`SPDIC_SCHG_OVR]  = overrun_status;
        schg_image[`SPDIC_SCHG_CTS]  = cts_level_status;
        schg_image[`SPDIC_SCHG_BRK]  = break_detected_i;
        schg_image[`SPDIC_SCHG_TX_READY_STATUS] = tx_ready_i;
        schg_image[`SPDIC_SCHG_ALLS] = tx_all_sent_i;
    end

    // read mux; unmapped addresses and idle cycles give zero,
    // so stale data never lingers on the bus
    assign next_rdata = !rd_i    ? 32'h0000_0000 :
                        hit_ctrl ? ctrl_image :
                        hit_stat ? stat_image :
                        hit_schg ? schg_image : 32'h0000_0000;

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------

    // software owns every bit; reset clears all enables and fields
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_dma_enable        <= CTRL_RESET_VAL[`SPDIC_CTRL_TX_DMA];
            rx_dma_enable        <= CTRL_RESET_VAL[`SPDIC_CTRL_RX_DMA];
            tx_space_irq_enable  <= CTRL_RESET_VAL[`SPDIC_CTRL_TX_IRQ];
            rx_full_irq_enable   <= CTRL_RESET_VAL[`SPDIC_CTRL_RX_IRQ];
            rx_error_irq_enable  <= CTRL_RESET_VAL[`SPDIC_CTRL_ERR_IRQ];
            cts_edge_condition   <= spdic_pkg::SPDIC_CTS_NONE;
            status_change_select <= CTRL_RESET_VAL[`SPDIC_CTRL_SEL_HI:`SPDIC_CTRL_SEL_LO];
        end else if (wr_ctrl) begin
            tx_dma_enable        <= wdata_i[`SPDIC_CTRL_TX_DMA];
            rx_dma_enable        <= wdata_i[`SPDIC_CTRL_RX_DMA];
            tx_space_irq_enable  <= wdata_i[`SPDIC_CTRL_TX_IRQ];
            rx_full_irq_enable   <= wdata_i[`SPDIC_CTRL_RX_IRQ];
            rx_error_irq_enable  <= wdata_i[`SPDIC_CTRL_ERR_IRQ];
            cts_edge_condition   <= spdic_pkg::spdic_cts_cond_t'(
                                    wdata_i[`SPDIC_CTRL_CTS_HI:`SPDIC_CTRL_CTS_LO]);
            status_change_select <= wdata_i[`SPDIC_CTRL_SEL_HI:`SPDIC_CTRL_SEL_LO];
        end
    end

    // ------------------------------------------------------------------------
    // cts pin synchroniser
    // ------------------------------------------------------------------------

    // three stages; the level only moves once the last two agree, so a
    // metastable first stage never reaches the edge detector
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cts_s1           <= 1'b0;
            cts_s2           <= 1'b0;
            cts_s3           <= 1'b0;
            cts_level_status <= 1'b0;
        end else begin
            cts_s1 <= cts_pin_i;
            cts_s2 <= cts_s1;
            cts_s3 <= cts_s2;
            if (cts_s2 == cts_s3) begin
                cts_level_status <= cts_s3;
            end
        end
    end

    // ------------------------------------------------------------------------
    // status change detection
    // ------------------------------------------------------------------------
    assign stchg.overrun_status       = overrun_status;
    assign stchg.cts_level_status     = cts_level_status;
    assign stchg.break_detected       = break_detected_i;
    assign stchg.tx_ready_status      = tx_ready_i;
    assign stchg.tx_all_sent          = tx_all_sent_i;
    assign stchg.status_change_select = status_change_select;
    assign stchg.cts_edge_condition   = cts_edge_condition;

    spdic_stchg u_stchg (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .sc        (stchg.det)
    );

    // ------------------------------------------------------------------------
    // latched status flags
    // ------------------------------------------------------------------------

    // every flag is set by hardware and cleared by a written zero; a set in
    // the clearing cycle survives, so no event is lost to a racing write
    assign next_rx_error_flag   = flag_next(rx_error_flag, rx_error_i,
                                  wr_zero(wr_stat, wdata_i, `SPDIC_STAT_ERR));

    assign next_rx_timeout_flag = flag_next(rx_timeout_flag, rx_timeout_i,
                                  wr_zero(wr_stat, wdata_i, `SPDIC_STAT_RX_TIMEOUT_FLAG));

    // the dma acknowledge also clears; while the level holds it sets again
    assign next_tx_space_flag   = flag_next(tx_space_flag, tx_space_lvl_i,
                                  wr_zero(wr_stat, wdata_i, `SPDIC_STAT_TXSP) | tx_dma_ack_i);

    assign next_rx_full_flag    = flag_next(rx_full_flag, rx_full_lvl_i,
                                  wr_zero(wr_stat, wdata_i, `SPDIC_STAT_RXFULL) | rx_dma_ack_i);

    assign next_status_change_flag = flag_next(status_change_flag, stchg.hit,
                                  wr_zero(wr_stat, wdata_i, `SPDIC_STAT_SCHG));

    assign next_overrun_status  = flag_next(overrun_status, overrun_i,
                                  wr_zero(wr_schg, wdata_i, `SPDIC_SCHG_OVR));

    // tx space resets set: an empty fifo has room
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_error_flag      <= 1'b0;
            rx_timeout_flag    <= 1'b0;
            tx_space_flag      <= `SPDIC_TXSP_RESET;
            rx_full_flag       <= 1'b0;
            status_change_flag <= 1'b0;
            overrun_status     <= 1'b0;
        end else begin
            rx_error_flag      <= next_rx_error_flag;
            rx_timeout_flag    <= next_rx_timeout_flag;
            tx_space_flag      <= next_tx_space_flag;
            rx_full_flag       <= next_rx_full_flag;
            status_change_flag <= next_status_change_flag;
            overrun_status     <= next_overrun_status;
        end
    end

    // ------------------------------------------------------------------------
    // dma requests and modes
    // ------------------------------------------------------------------------

    // the line logic uses the mode bits to know whether dma or software
    // feeds and drains the fifos
    assign tx_dma_mode_o = tx_dma_enable;
    assign rx_dma_mode_o = rx_dma_enable;

    // requests come straight from flops so an ack drops them next cycle
    assign tx_dma_req_o  = tx_dma_enable & tx_space_flag;
    assign rx_dma_req_o  = rx_dma_enable & rx_full_flag;

    // ------------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------------

    // software is trusted to keep the irq enables off in dma mode; if it does
    // not, both the request and the interrupt fire
    wire irq_tx   = tx_space_irq_enable & tx_space_flag;
    wire irq_rx   = rx_full_irq_enable & (rx_full_flag | rx_timeout_flag);
    wire irq_err  = rx_error_irq_enable & rx_error_flag;
    wire irq_schg = status_change_flag;

    // no priority among the causes
    assign irq_o  = irq_tx
                  | irq_rx
                  | irq_err
                  | irq_schg;

endmodule : spdic_top

/* File: spdic_dma_model.sv */
// dma controller model facing the block's two request lines
// assumes requests are levels on clk_i and an acknowledge clears them
`timescale 1ns/1ps

module spdic_dma_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // requests in, answer delay, acknowledges out
    input  wire logic [1:0] req_i,
    input  wire logic [3:0] delay_i,
    output logic      [1:0] ack_o
);
    logic [3:0] wait_cnt [2];

    // one-cycle ack after delay_i+1 cycles of request; no ack right after an ack,
    // since the request only falls one cycle after the ack, at the edge where the flag clears
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        for (int i = 0; i < 2; i++) begin
            if (!reset_n_i) begin
                wait_cnt[i] <= 4'h0;
                ack_o[i]    <= 1'b0;
            end else begin
                ack_o[i]    <= req_i[i] && !ack_o[i] && wait_cnt[i] == delay_i;
                wait_cnt[i] <= (req_i[i] && !ack_o[i] && wait_cnt[i] != delay_i) ? wait_cnt[i] + 4'h1 : 4'h0;
            end
        end
    end
endmodule : spdic_dma_model

/* File: spdic_top_monitor.sv */
// port checker for the dma and interrupt request control
// assumes it is bound to spdic_top and sees only its ports
`timescale 1ns/1ps
`include "spdic_regs.svh"

module spdic_top_monitor #(
    parameter bit CHANNEL = 1'b0
) (
    // clock, reset, register port
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    // line status
    input wire logic        tx_space_lvl_i,
    input wire logic        rx_full_lvl_i,
    input wire logic        rx_timeout_i,
    input wire logic        rx_error_i,
    input wire logic        overrun_i,
    // outputs watched
    input wire logic        tx_dma_req_o,
    input wire logic        rx_dma_req_o,
    input wire logic        tx_dma_mode_o,
    input wire logic        irq_o
);
    // --------
    // control shadow, rebuilt from bus writes
    // --------
    logic [15:0] ctl;
    wire         ctl_wr = wr_i && addr_i == (CHANNEL ? `SPDIC_ADDR_CTRL_CH1 : `SPDIC_ADDR_CTRL_CH0);

    // a status write may clear a flag and a control write may change an enable, so causes below exclude write cycles
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i) ctl <= 16'h0000;
        else if (ctl_wr) ctl <= wdata_i[15:0];

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_tx_req_mode: assert property (tx_dma_req_o |-> ctl[15])
        else $error("tx dma request outside dma mode");
    a_rx_req_mode: assert property (rx_dma_req_o |-> ctl[14])
        else $error("rx dma request outside dma mode");
    a_tx_mode_write: assert property (ctl_wr |=> tx_dma_mode_o == $past(wdata_i[15]))
        else $error("tx dma mode does not follow control write");
    a_rx_full_req: assert property (ctl[14] && rx_full_lvl_i && !wr_i |=> rx_dma_req_o)
        else $error("rx dma request missing");
    a_tx_space_irq: assert property (ctl[13] && tx_space_lvl_i && !wr_i |=> irq_o)
        else $error("tx space interrupt missing");
    a_rx_data_irq: assert property (ctl[12] && (rx_full_lvl_i || rx_timeout_i) && !wr_i |=> irq_o)
        else $error("rx interrupt missing");
    a_rx_err_irq: assert property (ctl[11] && rx_error_i && !wr_i |=> irq_o)
        else $error("error interrupt missing");
    a_overrun_irq: assert property (ctl[5] && overrun_i && !wr_i ##1 !wr_i |=> irq_o)
        else $error("overrun status change interrupt missing");
endmodule : spdic_top_monitor

bind spdic_top spdic_top_monitor #(.CHANNEL(CHANNEL)) spdic_top_monitor_inst (.clk_i, .reset_n_i, .addr_i,
    .wdata_i, .wr_i, .tx_space_lvl_i, .rx_full_lvl_i, .rx_timeout_i, .rx_error_i, .overrun_i,
    .tx_dma_req_o, .rx_dma_req_o, .tx_dma_mode_o, .irq_o);

/* File: spdic_tb.sv */
// self-checking bench for the dma and interrupt request control
// assumes the dma model and the bound checker are compiled before it
`timescale 1ns/1ps
`include "spdic_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tb;
    typedef struct packed { logic [15:0] c; logic [4:0] e; logic q; } spdic_row_t;
    // events are tx space, rx full, timeout, error, overrun; dma row stays quiet
    localparam spdic_row_t ROWS [10] = '{'{16'h2000, 5'h10, 1'b1}, '{16'h0000, 5'h10, 1'b0},
        '{16'h1000, 5'h08, 1'b1}, '{16'h1000, 5'h04, 1'b1}, '{16'h0800, 5'h02, 1'b1}, '{16'h1000, 5'h02, 1'b0},
        '{16'h0020, 5'h01, 1'b1}, '{16'h0000, 5'h01, 1'b0}, '{16'h001f, 5'h01, 1'b0}, '{16'hc000, 5'h08, 1'b0}};
    localparam logic [15:0] CTRL = `SPDIC_ADDR_CTRL_CH0;
    localparam logic [15:0] STAT = `SPDIC_ADDR_STAT_CH0;
    logic        clk_i, reset_n_i, wr_i, rd_i, cts, tx_mode, rx_mode, irq;
    logic [15:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [4:0]  ev;
    logic [3:1]  lv;
    logic [3:0]  dly;
    logic [1:0]  req, ack;
    int          n_errors, check_count;

    spdic_top #(.CHANNEL(1'b0)) spdic_top_inst (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .tx_space_lvl_i(ev[4]), .rx_full_lvl_i(ev[3]), .rx_timeout_i(ev[2]), .rx_error_i(ev[1]), .overrun_i(ev[0]),
        .break_detected_i(lv[3]), .tx_ready_i(lv[2]), .tx_all_sent_i(lv[1]), .rx_count_i(5'h00), .rx_head_i(5'h00),
        .cts_pin_i(cts), .tx_dma_ack_i(ack[1]), .rx_dma_ack_i(ack[0]), .tx_dma_req_o(req[1]), .rx_dma_req_o(req[0]),
        .tx_dma_mode_o(tx_mode), .rx_dma_mode_o(rx_mode), .irq_o(irq));
    spdic_dma_model spdic_dma_model_inst (.clk_i, .reset_n_i, .req_i(req), .delay_i(dly), .ack_o(ack));

    // --------
    // bus tasks
    // --------
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, x)
    endtask : rd
    // select off first, so a level-type overrun cannot set the flag again
    task automatic clr();
        wr(CTRL, 32'h0); wr(`SPDIC_ADDR_SCHG_CH0, 32'h0); wr(STAT, 32'h0);
    endtask : clr
    task automatic pulse(input logic [4:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 5'h00;
    endtask : pulse
    task automatic summarize();
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        summarize();
    end

    initial begin
        reset_n_i = 0; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0; ev = 0; lv = 0; cts = 0; dly = 0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(STAT, 32'h100);
        foreach (ROWS[k]) begin
            clr();
            wr(CTRL, {16'h0, ROWS[k].c});
            #1 `CHK(irq, 1'b0)
            pulse(ROWS[k].e);
            repeat (3) @(posedge clk_i);
            #1 `CHK(irq, ROWS[k].q)
            `CHK(tx_mode, ROWS[k].c[15])
            rd(CTRL, {16'h0, ROWS[k].c});
        end
        // slow dma answer: both requests hold until acknowledged
        clr(); dly <= 4'h4; wr(CTRL, 32'hc000); pulse(5'h18);
        #1 `CHK(req, 2'b11)
        repeat (4) @(posedge clk_i);
        #1 `CHK(req, 2'b11)
        repeat (8) @(posedge clk_i);
        #1 `CHK(req, 2'b00)
        // writing ones leaves the error flag, writing zero clears it
        clr(); wr(CTRL, 32'h0800); pulse(5'h02); wr(STAT, 32'hffffffff);
        rd(STAT, 32'h400);
        wr(STAT, 32'h0); rd(STAT, 32'h0);
        for (int c = 0; c < 4; c++) begin
            clr(); wr(CTRL, 32'h10 | (c << 9));
            @(posedge clk_i) cts <= 1'b1;
            repeat (8) @(posedge clk_i);
            #1 `CHK(irq, c[0])
            wr(STAT, 32'h0);
            @(posedge clk_i) cts <= 1'b0;
            repeat (8) @(posedge clk_i);
            #1 `CHK(irq, c[1])
        end
        // a level that stays high must not set the flag again
        for (int i = 1; i < 4; i++) begin
            clr(); wr(CTRL, 32'h1 << i);
            @(posedge clk_i) lv[i] <= 1'b1;
            repeat (3) @(posedge clk_i);
            #1 `CHK(irq, 1'b1)
            wr(STAT, 32'h0);
            #1 `CHK(irq, 1'b0)
            @(posedge clk_i) lv <= 3'h0;
        end
        wr(CTRL, 32'hfe3f);
        @(posedge clk_i) reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(CTRL, 32'h0);
        `CHK(rx_mode, 1'b0)
        summarize();
    end
endmodule : tb
